//--- ecsg_cfg.svh
// Constants for the Ethernet command source guard: register map, fields, reset values, timing.
// Assumes a 10 MHz pclk and 32-bit APB; included by its bare name.
`ifndef ECSG_CFG_SVH
`define ECSG_CFG_SVH
`define ECSG_ADDR_SRC_IP 8'h00
`define ECSG_ADDR_SRC_RNG 8'h04
`define ECSG_ADDR_FLT_IP 8'h08
`define ECSG_ADDR_FLT_R23 8'h0C
`define ECSG_ADDR_FLT_R4 8'h10
`define ECSG_ADDR_LOSS_IVL 8'h14
`define ECSG_ADDR_CTRL 8'h18
`define ECSG_ADDR_STATUS 8'h1C
`define ECSG_ADDR_MASK 8'h20
`define ECSG_ADDR_STATE 8'h24
`define ECSG_RANGE_OFF 16'h270F
`define ECSG_IVL_OFF 16'h270F
`define ECSG_IVL_NOW 16'h0000
`define ECSG_RST_IP 32'h0000_0000
`define ECSG_RST_RNG 32'h270F_270F
`define ECSG_RST_IVL 16'h000F
`define ECSG_ST_LOSS 0
`define ECSG_ST_CMD_REJ 1
`define ECSG_ST_CONN_REJ 2
`define ECSG_CTRL_APPLY 0
`define ECSG_NSTAT 3
`define ECSG_CLK_PERIOD_NS 100
`define ECSG_IVL_UNIT_NS 100000000
`endif

//--- ecsg_pkg.sv
// Types shared by the command source guard and its surroundings.
// Assumes ecsg_cfg.svh holds the numeric constants.
package ecsg_pkg;
    typedef struct packed {
        logic valid;
        logic is_cmd;
        logic [31:0] src_ip;
    } ecsg_frame_t;
    typedef struct packed {
        logic valid;
        logic connect_ok;
        logic cmd_ok;
    } ecsg_verdict_t;
    typedef enum logic [1:0] {SUP_IDLE, SUP_ARMED, SUP_RUN, SUP_FAULT} ecsg_sup_t;
endpackage

//--- ecsg_guard.sv
// Ethernet command source guard: address filters, command source check, loss supervision.
// Assumes an APB master on pclk and frames presented as one-cycle pulses from the MAC side.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "ecsg_cfg.svh"
module ecsg_guard #(
    parameter int unsigned TICK_CYCLES = `ECSG_IVL_UNIT_NS / `ECSG_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received frames and verdicts
    input wire ecsg_pkg::ecsg_frame_t rx_frame,
    output ecsg_pkg::ecsg_verdict_t verdict,
    // Operating mode
    input wire logic net_mode,
    input wire logic eth_cmd_src,
    // Fault and interrupt
    output logic comm_loss_fault,
    output logic output_shutoff,
    output logic irq
);
    // Written copies and the copies in use
    logic [31:0] src_ip_q, src_rng_q, flt_ip_q, flt_r23_q, flt_r4_q;
    logic [15:0] ivl_q;
    logic [31:0] act_src_ip_q, act_src_rng_q, act_flt_ip_q, act_flt_r23_q, act_flt_r4_q;
    logic [15:0] act_ivl_q;
    logic [`ECSG_NSTAT-1:0] status_q, mask_q, stat_set;
    logic apply;
    logic wr, rd;
    logic [31:0] rdata_d;
    logic map_hit;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    assign pready = 1'b1;
    assign apply = wr && paddr == `ECSG_ADDR_CTRL && pwdata[`ECSG_CTRL_APPLY];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_ip_q <= `ECSG_RST_IP;
            src_rng_q <= `ECSG_RST_RNG;
            flt_ip_q <= `ECSG_RST_IP;
            flt_r23_q <= `ECSG_RST_RNG;
            flt_r4_q <= `ECSG_RST_RNG;
            ivl_q <= `ECSG_RST_IVL;
            mask_q <= '0;
        end else if (wr) begin
            case (paddr)
                `ECSG_ADDR_SRC_IP: src_ip_q <= pwdata;
                `ECSG_ADDR_SRC_RNG: src_rng_q <= pwdata;
                `ECSG_ADDR_FLT_IP: flt_ip_q <= pwdata;
                `ECSG_ADDR_FLT_R23: flt_r23_q <= pwdata;
                `ECSG_ADDR_FLT_R4: flt_r4_q <= pwdata;
                `ECSG_ADDR_LOSS_IVL: ivl_q <= pwdata[15:0];
                `ECSG_ADDR_MASK: mask_q <= pwdata[`ECSG_NSTAT-1:0];
                default: ;
            endcase
        end
    end

    // Settings in use change only on a reset or a soft reset command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_src_ip_q <= `ECSG_RST_IP;
            act_src_rng_q <= `ECSG_RST_RNG;
            act_flt_ip_q <= `ECSG_RST_IP;
            act_flt_r23_q <= `ECSG_RST_RNG;
            act_flt_r4_q <= `ECSG_RST_RNG;
            act_ivl_q <= `ECSG_RST_IVL;
        end else if (apply) begin
            act_src_ip_q <= src_ip_q;
            act_src_rng_q <= src_rng_q;
            act_flt_ip_q <= flt_ip_q;
            act_flt_r23_q <= flt_r23_q;
            act_flt_r4_q <= flt_r4_q;
            act_ivl_q <= ivl_q;
        end
    end

    // Address matching, one octet per loop pass; octet 0 is the first (most significant)
    logic [15:0] src_bound [4];
    logic [15:0] flt_bound [4];
    logic [3:0] src_oct_ok, flt_oct_ok;
    logic src_none, flt_none, src_ok, flt_ok;

    assign src_bound[0] = `ECSG_RANGE_OFF;
    assign src_bound[1] = `ECSG_RANGE_OFF;
    assign src_bound[2] = act_src_rng_q[15:0];
    assign src_bound[3] = act_src_rng_q[31:16];
    assign flt_bound[0] = `ECSG_RANGE_OFF;
    assign flt_bound[1] = act_flt_r23_q[15:0];
    assign flt_bound[2] = act_flt_r23_q[31:16];
    assign flt_bound[3] = act_flt_r4_q[15:0];

    function automatic logic oct_match(input logic [7:0] oct, input logic [7:0] base,
                                       input logic [15:0] bound);
        logic [15:0] lo;
        logic [15:0] hi;
        lo = {8'h00, base};
        hi = bound;
        if (bound == `ECSG_RANGE_OFF)
            return oct == base;
        if (bound < lo) begin
            lo = bound;
            hi = {8'h00, base};
        end
        return {8'h00, oct} >= lo && {8'h00, oct} <= hi;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_oct
            localparam int SH = 24 - 8 * gi;
            assign src_oct_ok[gi] = oct_match(rx_frame.src_ip[SH+:8], act_src_ip_q[SH+:8],
                                              src_bound[gi]);
            assign flt_oct_ok[gi] = oct_match(rx_frame.src_ip[SH+:8], act_flt_ip_q[SH+:8],
                                              flt_bound[gi]);
        end
    endgenerate

    assign src_none = act_src_ip_q == `ECSG_RST_IP;
    assign flt_none = act_flt_ip_q == `ECSG_RST_IP;
    assign flt_ok = flt_none || &flt_oct_ok;
    assign src_ok = !src_none && &src_oct_ok && flt_ok;

    // Verdict register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            verdict <= '0;
        end else begin
            verdict.valid <= rx_frame.valid;
            verdict.connect_ok <= rx_frame.valid && flt_ok;
            verdict.cmd_ok <= rx_frame.valid && rx_frame.is_cmd && src_ok;
        end
    end

    // Supervision of permitted hosts
    logic net_eth, net_eth_q, permitted_rx, tick;
    logic [31:0] div_q;
    logic [15:0] gap_q;
    ecsg_pkg::ecsg_sup_t sup_q;

    assign net_eth = net_mode && eth_cmd_src;
    assign permitted_rx = rx_frame.valid && src_ok;
    assign tick = div_q == TICK_CYCLES - 1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            net_eth_q <= 1'b0;
        else
            net_eth_q <= net_eth;
    end

    // Tenth-second enable; restarted on each permitted reception
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            div_q <= '0;
        else if (permitted_rx || tick || sup_q != ecsg_pkg::SUP_RUN)
            div_q <= '0;
        else
            div_q <= div_q + 32'h0000_0001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            gap_q <= '0;
        else if (permitted_rx || sup_q != ecsg_pkg::SUP_RUN)
            gap_q <= '0;
        else if (tick)
            gap_q <= gap_q + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_q <= ecsg_pkg::SUP_IDLE;
        end else if (apply) begin
            sup_q <= ecsg_pkg::SUP_IDLE;
        end else begin
            case (sup_q)
                ecsg_pkg::SUP_IDLE: begin
                    if (act_ivl_q == `ECSG_IVL_OFF)
                        sup_q <= ecsg_pkg::SUP_IDLE;
                    else if (act_ivl_q == `ECSG_IVL_NOW && net_eth && !net_eth_q)
                        sup_q <= ecsg_pkg::SUP_FAULT;
                    else if (act_ivl_q != `ECSG_IVL_NOW && net_eth)
                        sup_q <= ecsg_pkg::SUP_ARMED;
                end
                ecsg_pkg::SUP_ARMED: begin
                    if (!net_eth)
                        sup_q <= ecsg_pkg::SUP_IDLE;
                    else if (permitted_rx)
                        sup_q <= ecsg_pkg::SUP_RUN;
                end
                ecsg_pkg::SUP_RUN: begin
                    if (tick && !permitted_rx && gap_q + 16'h0001 >= act_ivl_q)
                        sup_q <= ecsg_pkg::SUP_FAULT;
                end
                ecsg_pkg::SUP_FAULT: sup_q <= ecsg_pkg::SUP_FAULT;
                default: sup_q <= ecsg_pkg::SUP_IDLE;
            endcase
        end
    end

    assign comm_loss_fault = sup_q == ecsg_pkg::SUP_FAULT;
    assign output_shutoff = comm_loss_fault;

    // Sticky events; a new event wins over a clear in the same cycle
    assign stat_set[`ECSG_ST_LOSS] = comm_loss_fault;
    assign stat_set[`ECSG_ST_CMD_REJ] = rx_frame.valid && rx_frame.is_cmd && !src_ok;
    assign stat_set[`ECSG_ST_CONN_REJ] = rx_frame.valid && !flt_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            status_q <= '0;
        else if (wr && paddr == `ECSG_ADDR_STATUS)
            status_q <= (status_q & ~pwdata[`ECSG_NSTAT-1:0]) | stat_set;
        else
            status_q <= status_q | stat_set;
    end

    assign irq = |(status_q & mask_q);

    // Read path
    always_comb begin
        map_hit = 1'b1;
        rdata_d = '0;
        case (paddr)
            `ECSG_ADDR_SRC_IP: rdata_d = src_ip_q;
            `ECSG_ADDR_SRC_RNG: rdata_d = src_rng_q;
            `ECSG_ADDR_FLT_IP: rdata_d = flt_ip_q;
            `ECSG_ADDR_FLT_R23: rdata_d = flt_r23_q;
            `ECSG_ADDR_FLT_R4: rdata_d = flt_r4_q;
            `ECSG_ADDR_LOSS_IVL: rdata_d = {16'h0000, ivl_q};
            `ECSG_ADDR_CTRL: rdata_d = '0;
            `ECSG_ADDR_STATUS: rdata_d = {29'h0000_0000, status_q};
            `ECSG_ADDR_MASK: rdata_d = {29'h0000_0000, mask_q};
            `ECSG_ADDR_STATE: rdata_d = {28'h000_0000, sup_q, irq, comm_loss_fault};
            default: map_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= '0;
        else if (rd && !penable)
            prdata <= rdata_d;
    end

    assign pslverr = psel && penable && !map_hit;

    // Checks
    sequence s_entry_now;
        act_ivl_q == `ECSG_IVL_NOW && net_eth && !net_eth_q && sup_q == ecsg_pkg::SUP_IDLE && !apply;
    endsequence

    sequence s_silent_trip;
        sup_q == ecsg_pkg::SUP_RUN && tick && !permitted_rx && !apply && gap_q + 16'h0001 >= act_ivl_q;
    endsequence

    a_zero_src_reject: assert property (@(posedge pclk) disable iff (!presetn)
        rx_frame.valid && src_none |=> !verdict.cmd_ok)
        else $error("command accepted with no source configured");
    a_exact_oct_one: assert property (@(posedge pclk) disable iff (!presetn)
        verdict.cmd_ok |-> $past(rx_frame.src_ip[31:16]) == $past(act_src_ip_q[31:16]))
        else $error("first octets accepted without exact match");
    a_range_accept: assert property (@(posedge pclk) disable iff (!presetn)
        rx_frame.valid && rx_frame.is_cmd && !src_none && flt_ok && src_oct_ok[1:0] == 2'b11
        && src_oct_ok[3:2] == 2'b11 |=> verdict.cmd_ok)
        else $error("in-range command refused");
    a_range_off_exact: assert property (@(posedge pclk) disable iff (!presetn)
        src_bound[3] == `ECSG_RANGE_OFF && src_oct_ok[3] |-> rx_frame.src_ip[7:0] == act_src_ip_q[7:0])
        else $error("disabled range did not demand exact octet");
    a_loss_shutoff: assert property (@(posedge pclk) disable iff (!presetn)
        s_silent_trip |=> comm_loss_fault && output_shutoff)
        else $error("silence did not trip fault");
    a_no_supervise: assert property (@(posedge pclk) disable iff (!presetn)
        act_ivl_q == `ECSG_IVL_OFF && sup_q == ecsg_pkg::SUP_IDLE && !apply |=> sup_q == ecsg_pkg::SUP_IDLE)
        else $error("supervision ran while disabled");
    a_zero_ivl_fault: assert property (@(posedge pclk) disable iff (!presetn)
        s_entry_now |=> comm_loss_fault)
        else $error("zero interval did not fault on network entry");
    a_rx_clears_gap: assert property (@(posedge pclk) disable iff (!presetn)
        permitted_rx |=> gap_q == 16'h0000)
        else $error("permitted reception did not clear count");
    a_start_first_rx: assert property (@(posedge pclk) disable iff (!presetn)
        sup_q == ecsg_pkg::SUP_ARMED && net_eth && !permitted_rx && !apply |=> sup_q == ecsg_pkg::SUP_ARMED)
        else $error("supervision started before first reception");
    a_filter_reject: assert property (@(posedge pclk) disable iff (!presetn)
        rx_frame.valid && !flt_none && !(&flt_oct_ok) |=> !verdict.connect_ok && !verdict.cmd_ok)
        else $error("filtered host accepted");
    a_hold_settings: assert property (@(posedge pclk) disable iff (!presetn)
        !apply |=> $stable(act_src_ip_q) && $stable(act_ivl_q) && $stable(act_flt_ip_q))
        else $error("settings in use changed without reset");
    a_gap_bounded: assert property (@(posedge pclk) disable iff (!presetn)
        sup_q == ecsg_pkg::SUP_RUN |-> gap_q < act_ivl_q)
        else $error("gap exceeded interval without fault");
endmodule

//--- ecsg_host_model.sv
// Networked master model: sends frames that carry a source address to the guard.
// Assumes the guard samples rx_frame on the rising edge of pclk.
`timescale 1ns/1ps
module ecsg_host_model (
    // Clock
    input wire logic pclk,
    // Frames toward the guard
    output ecsg_pkg::ecsg_frame_t rx_frame
);
    initial begin
        rx_frame = '0;
    end
    // One-cycle frame; afterwards the lines show the inverse so stale values never match
    task automatic send(input logic [31:0] ip, input logic cmd);
        @(posedge pclk);
        rx_frame <= '{valid: 1'b1, is_cmd: cmd, src_ip: ip};
        @(posedge pclk);
        rx_frame <= '{valid: 1'b0, is_cmd: ~cmd, src_ip: ~ip};
    endtask
endmodule

//--- tb_ethernet_command_source_guard.sv
// Self-checking bench for the command source guard: filters, interrupts, loss supervision.
// Assumes ecsg_cfg.svh register map and a host model that delivers frames.
`timescale 1ns/1ps
`include "ecsg_cfg.svh"
module tb_ethernet_command_source_guard;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, cs, cr, fi, f23, f4, ip;
    logic pready, pslverr, err, comm_loss_fault, output_shutoff, irq;
    logic net_mode = 1'b0;
    logic eth_cmd_src = 1'b0;
    ecsg_pkg::ecsg_frame_t rx_frame;
    ecsg_pkg::ecsg_verdict_t verdict;
    int n_fail = 0;
    int compares = 0;
    logic [31:0] tbl [8] = '{32'hC0A80164, 32'hC0A80396, 32'hC0A80363, 32'hC0A80497,
        32'hC0A80232, 32'hC0A80231, 32'hC0A80464, 32'hC1A80164};
    always #50 pclk = ~pclk;
    ecsg_guard #(.TICK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_frame(rx_frame), .verdict(verdict), .net_mode(net_mode),
        .eth_cmd_src(eth_cmd_src), .comm_loss_fault(comm_loss_fault),
        .output_shutoff(output_shutoff), .irq(irq));
    ecsg_host_model host (.pclk(pclk), .rx_frame(rx_frame));
    function automatic logic inr(input logic [7:0] v, input logic [7:0] b, input logic [15:0] r);
        if (r == `ECSG_RANGE_OFF)
            return v == b;
        return (v >= b && v <= r) || (v <= b && v >= r);
    endfunction
    function automatic logic conn_ok(input logic [31:0] a);
        if (fi == 32'h0)
            return 1'b1;
        return a[31:24] == fi[31:24] && inr(a[23:16], fi[23:16], f23[15:0])
            && inr(a[15:8], fi[15:8], f23[31:16]) && inr(a[7:0], fi[7:0], f4[15:0]);
    endfunction
    function automatic logic src_ok(input logic [31:0] a);
        return cs != 32'h0 && a[31:16] == cs[31:16] && inr(a[15:8], cs[15:8], cr[15:0])
            && inr(a[7:0], cs[7:0], cr[31:16]);
    endfunction
    task automatic finish_test;
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready is tied high, so this wait ends after one clock edge
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_reg(rd, exp);
    endtask
    task automatic cfg(input logic [31:0] s, r, f, g, h, l, input logic go);
        apb(1'b1, `ECSG_ADDR_SRC_IP, s);
        apb(1'b1, `ECSG_ADDR_SRC_RNG, r);
        apb(1'b1, `ECSG_ADDR_FLT_IP, f);
        apb(1'b1, `ECSG_ADDR_FLT_R23, g);
        apb(1'b1, `ECSG_ADDR_FLT_R4, h);
        apb(1'b1, `ECSG_ADDR_LOSS_IVL, l);
        if (go) begin
            apb(1'b1, `ECSG_ADDR_CTRL, 32'h1);
            {cs, cr, fi, f23, f4} = {s, r, f, g, h};
        end
    endtask
    task automatic frame(input logic [31:0] a, input logic cmd);
        host.send(a, cmd);
        #1;
        chk_bit(verdict.valid, 1'b1);
        chk_bit(verdict.connect_ok, conn_ok(a));
        if (cmd)
            chk_bit(verdict.cmd_ok, src_ok(a) && conn_ok(a));
    endtask
    task automatic burst;
        foreach (tbl[i])
            frame(tbl[i], 1'b1);
        repeat (30) begin
            ip = {($urandom % 4 == 0) ? 8'($urandom) : 8'hC0, ($urandom % 4 == 0) ? 8'hA9 : 8'hA8,
                8'($urandom % 6), 8'(45 + $urandom % 110)};
            frame(ip, 1'b1);
        end
    endtask
    initial begin
        ip = $urandom(18);
        {cs, cr, fi, f23, f4} = {32'h0, `ECSG_RST_RNG, 32'h0, `ECSG_RST_RNG, 32'h270F};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`ECSG_ADDR_SRC_IP, `ECSG_RST_IP);
        rdchk(`ECSG_ADDR_SRC_RNG, `ECSG_RST_RNG);
        rdchk(`ECSG_ADDR_LOSS_IVL, {16'h0, `ECSG_RST_IVL});
        rdchk(`ECSG_ADDR_MASK, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk_bit(err, 1'b1);
        chk_reg(rd, 32'h0);
        frame(32'hC0A80164, 1'b1);
        cfg(32'hC0A80164, {16'd150, 16'd3}, 32'h0, `ECSG_RST_RNG, 32'h270F, 32'h270F, 1'b0);
        frame(32'hC0A80164, 1'b1);
        rdchk(`ECSG_ADDR_SRC_IP, 32'hC0A80164);
        cfg(32'hC0A80164, {16'd150, 16'd3}, 32'h0, `ECSG_RST_RNG, 32'h270F, 32'h270F, 1'b1);
        burst();
        // Sticky status, mask and the level interrupt
        apb(1'b1, `ECSG_ADDR_STATUS, 32'h7);
        rdchk(`ECSG_ADDR_STATUS, 32'h0);
        apb(1'b1, `ECSG_ADDR_MASK, 32'h2);
        frame(32'h0A000001, 1'b1);
        @(posedge pclk);
        #1 chk_bit(irq, 1'b1);
        apb(1'b1, `ECSG_ADDR_STATUS, 32'h2);
        @(posedge pclk);
        #1 chk_bit(irq, 1'b0);
        apb(1'b1, `ECSG_ADDR_MASK, 32'h0);
        frame(32'h0A000001, 1'b1);
        @(posedge pclk);
        #1 chk_bit(irq, 1'b0);
        cfg(32'hC0A80264, {16'd50, 16'h270F}, 32'hC0A80000, {16'd3, 16'h270F}, 32'd255, 32'd3, 1'b1);
        burst();
        // The fixed table holds hosts outside the connect filter
        apb(1'b0, `ECSG_ADDR_STATUS, 32'h0);
        chk_bit(rd[`ECSG_ST_CONN_REJ], 1'b1);
        // Supervision with an interval of three ticks
        @(posedge pclk);
        net_mode <= 1'b1;
        eth_cmd_src <= 1'b1;
        repeat (40) @(posedge pclk);
        #1 chk_bit(comm_loss_fault, 1'b0);
        repeat (8) begin
            frame(cs, 1'b0);
            repeat (6) @(posedge pclk);
        end
        #1 chk_bit(comm_loss_fault, 1'b0);
        repeat (20) @(posedge pclk);
        #1 chk_bit(comm_loss_fault, 1'b1);
        chk_bit(output_shutoff, 1'b1);
        apb(1'b1, `ECSG_ADDR_MASK, 32'h1);
        @(posedge pclk);
        #1 chk_bit(irq, 1'b1);
        // State word: supervision in fault, interrupt and fault bits set
        rdchk(`ECSG_ADDR_STATE, 32'h0000_000F);
        apb(1'b0, `ECSG_ADDR_STATUS, 32'h0);
        chk_bit(rd[`ECSG_ST_LOSS], 1'b1);
        apb(1'b1, `ECSG_ADDR_MASK, 32'h0);
        net_mode <= 1'b0;
        cfg(cs, cr, fi, f23, f4, 32'h270F, 1'b1);
        net_mode <= 1'b1;
        frame(cs, 1'b0);
        repeat (100) @(posedge pclk);
        #1 chk_bit(comm_loss_fault, 1'b0);
        @(posedge pclk);
        net_mode <= 1'b0;
        cfg(cs, cr, fi, f23, f4, 32'h0, 1'b1);
        repeat (3) @(posedge pclk);
        #1 chk_bit(comm_loss_fault, 1'b0);
        @(posedge pclk);
        net_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        #1 chk_bit(comm_loss_fault, 1'b1);
        rdchk(`ECSG_ADDR_SRC_IP, cs);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1 chk_bit(comm_loss_fault, 1'b0);
        rdchk(`ECSG_ADDR_SRC_IP, `ECSG_RST_IP);
        finish_test();
    end
    initial begin
        #(100 * 20000);
        n_fail++;
        finish_test();
    end
endmodule
